//--- hdl/pia_map.svh
`ifndef PIA_MAP_SVH
`define PIA_MAP_SVH
// fast channel count and source positions
`define PIA_NUM_FAST 16
`define PIA_CH_WATCHDOG 0
`define PIA_CH_CUSTOM 1
`define PIA_CH_SER1_RX 2
`define PIA_CH_SER1_TX 3
`define PIA_CH_SER2_RX 4
`define PIA_CH_SER2_TX 5
`define PIA_CH_SPI 6
`define PIA_CH_TWO_WIRE 7
`define PIA_CH_PLATFORM 8
`define PIA_CH_LED 9
`define PIA_CH_LINK_RX 10
`define PIA_CH_LINK_TX 11
`define PIA_CH_TIMER 12
`define PIA_CH_FIRST_RSVD 13
// platform line limit and trigger codes
`define PIA_MAX_PLATFORM 32
`define PIA_TRIG_LEVEL 1'b0
`define PIA_TRIG_EDGE 1'b1
`define PIA_POL_HIGH 1'b1
// reset values
`define PIA_RESET_FAST 16'h0000
`define PIA_RESET_PLAT 32'h0000_0000
`endif

//--- hdl/pia_pkg.sv
package pia_pkg;
  // peripheral event sources feeding the fast channels
  typedef struct packed {
    logic watchdog_unit;
    logic custom_functions;
    logic serial_port_first_rx;
    logic serial_port_first_tx;
    logic serial_port_second_rx;
    logic serial_port_second_tx;
    logic spi_done;
    logic two_wire_controller;
    logic smart_led_driver;
    logic stream_link_unit_rx;
    logic stream_link_unit_tx;
    logic general_timer_unit;
  } pia_sources_type;

  // standard machine interrupts toward the core
  typedef struct packed {
    logic timer;
    logic software;
    logic external;
  } pia_machine_type;

  // platform controller state
  typedef struct packed {
    logic [31:0] prev;
    logic [31:0] pending;
    logic request;
  } pia_plat_state_type;

  // aggregation state
  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] pending;
    logic [3:0] top_index;
    logic top_valid;
  } pia_state_type;
endpackage : pia_pkg

//--- hdl/pia_platform_ctrl.sv
`timescale 1ns/100ps
`include "pia_map.svh"
// merges the platform lines into a single request
module pia_platform_ctrl #(
  parameter int NUM_LINES = `PIA_MAX_PLATFORM,
  parameter logic [31:0] TRIG_TYPE = {32{`PIA_TRIG_EDGE}},
  parameter logic [31:0] TRIG_POL = {32{`PIA_POL_HIGH}}
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [NUM_LINES-1:0] lines,
  input wire logic [NUM_LINES-1:0] line_ack,
  output logic request,
  output logic [NUM_LINES-1:0] line_pending
);
  pia_pkg::pia_plat_state_type state;
  pia_pkg::pia_plat_state_type next_state;
  logic [31:0] norm;
  logic [31:0] hit;

  // per-line trigger selection by build parameters, set wins over ack
  always_comb begin
    next_state = state;
    norm = `PIA_RESET_PLAT;
    norm[NUM_LINES-1:0] = lines ~^ TRIG_POL[NUM_LINES-1:0];
    hit = `PIA_RESET_PLAT;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (TRIG_TYPE[i] == `PIA_TRIG_EDGE) begin
        hit[i] = norm[i] & ~state.prev[i];
      end else begin
        hit[i] = norm[i];
      end
      next_state.pending[i] = hit[i] |
        (state.pending[i] & ~line_ack[i]);
    end
    next_state.prev = norm;
    next_state.request = |next_state.pending;
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign request = state.request;
  assign line_pending = state.pending[NUM_LINES-1:0];

  // merged request follows any pending line
  merged_req_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (|state.pending) |-> request)
    else $error("merged request missing");
endmodule : pia_platform_ctrl

//--- hdl/pia_irq_aggregation.sv
`timescale 1ns/100ps
`include "pia_map.svh"
// Notes on behaviour
// - timer, software and external inputs forwarded as machine interrupts.
// - external timer input counts only without the internal timer unit.
// - optional platform input vector, configurable width, at most 32.
// - all platform lines merge into one fast channel.
// - sixteen fast channels, 0 to 12 fed by internal peripherals and the merged platform request, 13 to 15 reserved.
// - channel index is priority; channel 0 highest, 15 lowest.
// - rising edge sets pending; a steady high does not re-set.
// - pending stays until software writes zero to its pending bit.
// - channels 2/3 first serial rx/tx, 4/5 second serial rx/tx.
// - channel 0 watchdog timeout, channel 1 custom functions event.
// - channel 6 spi, 7 two-wire, 8 merged platform request.
// - channel 9 led, 10/11 stream link rx/tx, 12 timer.
// - platform line trigger chosen by build parameters.
module pia_irq_aggregation #(
  parameter bit INTERNAL_TIMER_EN = 1'b0,
  parameter bit PLATFORM_EN = 1'b1,
  parameter int PLATFORM_LINES = `PIA_MAX_PLATFORM,
  parameter logic [31:0] PLATFORM_TRIG_TYPE = {32{`PIA_TRIG_EDGE}},
  parameter logic [31:0] PLATFORM_TRIG_POL = {32{`PIA_POL_HIGH}}
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ext_timer_irq,
  input wire logic internal_timer_irq,
  input wire logic software_irq,
  input wire logic external_irq,
  input wire logic [PLATFORM_LINES-1:0] platform_irq,
  input wire logic [PLATFORM_LINES-1:0] platform_ack,
  input wire pia_pkg::pia_sources_type sources,
  input wire logic pending_write,
  input wire logic [15:0] pending_wdata,
  output pia_pkg::pia_machine_type machine_irq,
  output logic [15:0] fast_irq_channel,
  output logic [PLATFORM_LINES-1:0] platform_pending,
  output logic fast_irq_valid,
  output logic [3:0] fast_irq_index
);
  pia_pkg::pia_state_type state;
  pia_pkg::pia_state_type next_state;
  logic [15:0] raw;
  logic [15:0] rise;
  logic [15:0] clear;
  logic plat_req;
  logic [PLATFORM_LINES-1:0] plat_pend;

  // lowest set index wins
  function automatic logic [3:0] pia_first_set(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'hF;
    for (int i = `PIA_NUM_FAST - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : pia_first_set

  // optional platform controller on channel 8
  generate
    if (PLATFORM_EN) begin : g_plat
      pia_platform_ctrl #(
        .NUM_LINES(PLATFORM_LINES),
        .TRIG_TYPE(PLATFORM_TRIG_TYPE),
        .TRIG_POL(PLATFORM_TRIG_POL)
      ) u_plat (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .lines(platform_irq),
        .line_ack(platform_ack),
        .request(plat_req),
        .line_pending(plat_pend)
      );
    end else begin : g_noplat
      assign plat_req = 1'b0;
      assign plat_pend = '0;
    end
  endgenerate

  // channel source mapping, peripherals plus merged platform request
  always_comb begin
    raw = `PIA_RESET_FAST;
    raw[`PIA_CH_WATCHDOG] = sources.watchdog_unit;
    raw[`PIA_CH_CUSTOM] = sources.custom_functions;
    raw[`PIA_CH_SER1_RX] = sources.serial_port_first_rx;
    raw[`PIA_CH_SER1_TX] = sources.serial_port_first_tx;
    raw[`PIA_CH_SER2_RX] = sources.serial_port_second_rx;
    raw[`PIA_CH_SER2_TX] = sources.serial_port_second_tx;
    raw[`PIA_CH_SPI] = sources.spi_done;
    raw[`PIA_CH_TWO_WIRE] = sources.two_wire_controller;
    raw[`PIA_CH_PLATFORM] = plat_req;
    raw[`PIA_CH_LED] = sources.smart_led_driver;
    raw[`PIA_CH_LINK_RX] = sources.stream_link_unit_rx;
    raw[`PIA_CH_LINK_TX] = sources.stream_link_unit_tx;
    raw[`PIA_CH_TIMER] = sources.general_timer_unit;
  end

  // edge detect, pending update, priority pick
  always_comb begin
    next_state = state;
    rise = raw & ~state.prev;
    clear = pending_write ? ~pending_wdata : `PIA_RESET_FAST;
    next_state.prev = raw;
    next_state.pending = rise | (state.pending & ~clear);
    for (int i = `PIA_CH_FIRST_RSVD; i < `PIA_NUM_FAST; i++) begin
      next_state.pending[i] = 1'b0;
    end
    next_state.top_valid = |next_state.pending;
    next_state.top_index = pia_first_set(next_state.pending);
  end

  // state register, reset clears history and flags
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // machine interrupt forwarding
  assign machine_irq.timer = INTERNAL_TIMER_EN ?
    internal_timer_irq : ext_timer_irq;
  assign machine_irq.software = software_irq;
  assign machine_irq.external = external_irq;
  assign fast_irq_channel = state.pending;
  assign fast_irq_valid = state.top_valid;
  assign fast_irq_index = state.top_index;
  assign platform_pending = plat_pend;

  // a rise with no clear sets the flag next cycle
  edge_sets_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (rise[0] && !(pending_write && !pending_wdata[0]))
      |=> fast_irq_channel[0])
    else $error("rising edge not latched");

  // steady high without rise does not re-set a cleared flag
  level_quiet_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ($past(raw[1]) && raw[1] && !fast_irq_channel[1])
      |=> !fast_irq_channel[1])
    else $error("steady level set flag again");

  // flag holds until a zero write clears it
  flag_holds_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (fast_irq_channel[2] && !(pending_write && !pending_wdata[2]))
      |=> fast_irq_channel[2])
    else $error("pending flag dropped");

  // zero write with no new edge clears the flag
  write_clears_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (pending_write && !pending_wdata[3] && !rise[3])
      |=> !fast_irq_channel[3])
    else $error("pending flag not cleared");

  // reserved channels never fire
  rsvd_quiet_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    fast_irq_channel[15:13] == 3'h0)
    else $error("reserved channel pending");

  // channel 0 pending reports index 0; valid tracks any flag
  prio_pick_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (fast_irq_channel[0] |-> fast_irq_index == 4'h0) and
    (fast_irq_valid == (|fast_irq_channel)))
    else $error("priority index wrong");

  // timer source selection
  timer_sel_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    machine_irq.timer ==
      (INTERNAL_TIMER_EN ? internal_timer_irq : ext_timer_irq))
    else $error("timer source wrong");

  // watchdog rise appears on channel 0 one cycle later
  wdt_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.watchdog_unit) && !pending_write
      |=> fast_irq_channel[0])
    else $error("watchdog channel wrong");

  // custom functions rise lands on channel 1
  custom_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.custom_functions) && !pending_write
      |=> fast_irq_channel[`PIA_CH_CUSTOM])
    else $error("custom channel wrong");

  // first serial receive lands on channel 2
  ser1_rx_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.serial_port_first_rx) && !pending_write
      |=> fast_irq_channel[`PIA_CH_SER1_RX])
    else $error("first serial rx channel wrong");

  // first serial transmit lands on channel 3
  ser1_tx_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.serial_port_first_tx) && !pending_write
      |=> fast_irq_channel[`PIA_CH_SER1_TX])
    else $error("first serial tx channel wrong");

  // second serial receive lands on channel 4
  ser2_rx_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.serial_port_second_rx) && !pending_write
      |=> fast_irq_channel[`PIA_CH_SER2_RX])
    else $error("second serial rx channel wrong");

  // second serial transmit lands on channel 5
  ser2_tx_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.serial_port_second_tx) && !pending_write
      |=> fast_irq_channel[`PIA_CH_SER2_TX])
    else $error("second serial tx channel wrong");

  // spi done lands on channel 6
  spi_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.spi_done) && !pending_write
      |=> fast_irq_channel[`PIA_CH_SPI])
    else $error("spi channel wrong");

  // two-wire done lands on channel 7
  two_wire_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.two_wire_controller) && !pending_write
      |=> fast_irq_channel[`PIA_CH_TWO_WIRE])
    else $error("two-wire channel wrong");

  // merged platform request lands on channel 8
  plat_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(plat_req) && !pending_write
      |=> fast_irq_channel[`PIA_CH_PLATFORM])
    else $error("platform channel wrong");

  // led buffer event lands on channel 9
  led_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.smart_led_driver) && !pending_write
      |=> fast_irq_channel[`PIA_CH_LED])
    else $error("led channel wrong");

  // stream receive lands on channel 10
  link_rx_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.stream_link_unit_rx) && !pending_write
      |=> fast_irq_channel[`PIA_CH_LINK_RX])
    else $error("stream rx channel wrong");

  // stream transmit lands on channel 11
  link_tx_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.stream_link_unit_tx) && !pending_write
      |=> fast_irq_channel[`PIA_CH_LINK_TX])
    else $error("stream tx channel wrong");

  // general timer lands on channel 12
  timer_map_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(sources.general_timer_unit) && !pending_write
      |=> fast_irq_channel[`PIA_CH_TIMER])
    else $error("timer channel wrong");

  // the reported channel is itself pending
  index_pending_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    fast_irq_valid |-> fast_irq_channel[fast_irq_index])
    else $error("reported channel not pending");

  // no channel of higher priority is pending
  none_higher_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    fast_irq_valid |-> ((fast_irq_channel &
      ((16'h0001 << fast_irq_index) - 16'h0001)) == `PIA_RESET_FAST))
    else $error("higher priority channel pending");

  // per channel edge, level and clear behaviour
  generate
    for (genvar c = 0; c < `PIA_NUM_FAST; c++) begin : g_chan
      // a flag only appears after a rise of its channel
      no_spurious_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(fast_irq_channel[c]) |-> $past(rise[c]))
        else $error("flag set without edge");
      // a steady high never sets a cleared flag
      steady_quiet_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        ($past(raw[c]) && raw[c] && !fast_irq_channel[c])
          |=> !fast_irq_channel[c])
        else $error("steady high set flag");
      // a zero write with no rise clears the flag
      clear_lands_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (pending_write && !pending_wdata[c] && !rise[c])
          |=> !fast_irq_channel[c])
        else $error("zero write did not clear");
    end
  endgenerate
endmodule : pia_irq_aggregation

//--- verif/pia_core_model.sv
`timescale 1ns/100ps
// core side: writes the pending csr to clear flags
module pia_core_model (
  input wire logic sys_clk,
  output logic pending_write,
  output logic [15:0] pending_wdata
);
  initial begin
    pending_write = 1'b0;
    pending_wdata = 16'hFFFF;
  end
  // one write cycle; zero bits clear the masked channels
  task automatic clear(input logic [15:0] mask);
    @(posedge sys_clk);
    pending_write <= 1'b1;
    pending_wdata <= ~mask;
    @(posedge sys_clk);
    pending_write <= 1'b0;
    pending_wdata <= mask; // idle data flips, never trusted
  endtask : clear
endmodule : pia_core_model

//--- verif/pia_irq_aggregation_tb.sv
`timescale 1ns/100ps
// bench for the interrupt aggregation block
module pia_irq_aggregation_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ext_timer_irq = 1'b0;
  logic internal_timer_irq = 1'b0;
  logic software_irq = 1'b0;
  logic external_irq = 1'b0;
  logic [31:0] plat = 32'h0000_0000;
  logic [31:0] ack = 32'h0000_0000;
  pia_pkg::pia_sources_type src = 12'h000;
  logic pending_write;
  logic [15:0] pending_wdata;
  pia_pkg::pia_machine_type machine_irq;
  logic [15:0] fast_irq_channel;
  logic [31:0] platform_pending;
  logic fast_irq_valid;
  logic [3:0] fast_irq_index;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int k;
  always #25 sys_clk = ~sys_clk;
  // lines 0 to 15 level triggered, 16 to 31 edge triggered
  pia_irq_aggregation #(.PLATFORM_TRIG_TYPE(32'hFFFF_0000)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .ext_timer_irq(ext_timer_irq), .internal_timer_irq(internal_timer_irq),
    .software_irq(software_irq), .external_irq(external_irq),
    .platform_irq(plat), .platform_ack(ack), .sources(src),
    .pending_write(pending_write), .pending_wdata(pending_wdata),
    .machine_irq(machine_irq), .fast_irq_channel(fast_irq_channel),
    .platform_pending(platform_pending), .fast_irq_valid(fast_irq_valid),
    .fast_irq_index(fast_irq_index));
  pia_core_model u_core (.sys_clk(sys_clk), .pending_write(pending_write),
    .pending_wdata(pending_wdata));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // n rising edges, then settle at the falling edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : step
  // flags plus valid and lowest pending index
  task automatic fast(input logic [15:0] e);
    logic [3:0] ix;
    ix = 4'hF;
    for (int i = 15; i >= 0; i--) if (e[i]) ix = 4'(i);
    chk(32'(fast_irq_channel), 32'(e));
    chk(32'({fast_irq_valid, fast_irq_index}), 32'({|e, ix}));
  endtask : fast
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  task automatic t_machine();
    @(posedge sys_clk);
    ext_timer_irq <= 1'b1;
    external_irq <= 1'b1;
    @(negedge sys_clk);
    chk(32'(machine_irq), 32'h5);
    @(posedge sys_clk);
    ext_timer_irq <= 1'b0;
    external_irq <= 1'b0;
    internal_timer_irq <= 1'b1;
    software_irq <= 1'b1;
    @(negedge sys_clk);
    chk(32'(machine_irq), 32'h2);
    $display("test machine done");
  endtask : t_machine
  // each source lands on its channel, clears, steady high ignored
  task automatic t_map();
    for (k = 0; k < 12; k++) begin
      @(posedge sys_clk);
      src[11-k] <= 1'b1;
      step(1);
      fast(16'h0001 << (k < 8 ? k : k + 1));
      u_core.clear(16'h0001 << (k < 8 ? k : k + 1));
      @(negedge sys_clk);
      fast(16'h0000);
      step(2);
      fast(16'h0000);
      @(posedge sys_clk);
      src[11-k] <= 1'b0;
    end
    $display("test map done");
  endtask : t_map
  task automatic t_prio();
    @(posedge sys_clk);
    src <= 12'hFFF;
    step(1);
    fast(16'h1EFF);
    u_core.clear(16'h0FFF);
    @(negedge sys_clk);
    fast(16'h1000);
    u_core.clear(16'h1000);
    @(posedge sys_clk);
    src <= 12'h000;
    $display("test prio done");
  endtask : t_prio
  // a rise in the clearing cycle keeps the flag
  task automatic t_race();
    @(posedge sys_clk);
    src[11] <= 1'b1;
    step(1);
    @(posedge sys_clk);
    src[11] <= 1'b0;
    fork
      begin
        step(0);
        @(posedge sys_clk);
        src[11] <= 1'b1;
      end
      u_core.clear(16'h0001);
    join
    @(negedge sys_clk);
    fast(16'h0001);
    u_core.clear(16'h0001);
    @(posedge sys_clk);
    src[11] <= 1'b0;
    $display("test race done");
  endtask : t_race
  task automatic t_plat();
    @(posedge sys_clk);
    plat <= 32'h8000_0020;
    step(1);
    chk(platform_pending, 32'h8000_0020);
    step(1);
    fast(16'h0100);
    @(posedge sys_clk);
    ack <= 32'hFFFF_FFFF;
    step(1);
    chk(platform_pending, 32'h0000_0020);
    @(posedge sys_clk);
    plat <= 32'h0000_0000;
    ack <= 32'hFFFF_FFFF;
    step(1);
    chk(platform_pending, 32'h0000_0000);
    @(posedge sys_clk);
    ack <= 32'h0000_0000;
    u_core.clear(16'h0100);
    step(2);
    fast(16'h0000);
    $display("test plat done");
  endtask : t_plat
  // cycle ceiling against hangs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    step(1);
    fast(16'h0000);
    chk(platform_pending, 32'h0000_0000);
    t_machine();
    t_map();
    t_prio();
    t_race();
    t_plat();
    results();
  end
endmodule : pia_irq_aggregation_tb
